// ### dv/drive_model.sv
`timescale 1ns/100ps
module drive_model (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic signed [15:0] drive_cmd,
  input  wire logic               drive_en,
  input  wire logic               push,
  input  wire logic signed [7:0]  push_cnt,
  output logic                    enc_a,
  output logic                    enc_b
);
  int         pend;
  int         div;
  logic [1:0] g;
  // one encoder step per 8 cycles; a push outruns the slowest servo tick rate used here
  always_ff @(posedge mclk) begin
    div <= (div + 1) % 8;
    if (srst) begin
      pend <= 0;
      g    <= 2'h0;
    end else if (push) begin
      pend <= pend + push_cnt;
    end else if (div == 0) begin
      // a pending push models an outside force and overrides the drive
      if (pend > 0) begin
        g    <= g + 2'h1;
        pend <= pend - 1;
      end else if (pend < 0) begin
        g    <= g - 2'h1;
        pend <= pend + 1;
      end else if (drive_en && drive_cmd > 0) begin
        g <= g + 2'h1;
      end else if (drive_en && drive_cmd < 0) begin
        g <= g - 2'h1;
      end
    end
  end
  // counting up means b changes first, which the axis decodes as an upward count
  assign enc_a = g[1];
  assign enc_b = g[1] ^ g[0];
endmodule // drive_model

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic               mclk, srst, psel, penable, pwrite, pready, pslverr;
  logic               enc_a, enc_b, drive_en, irq, push, perr;
  logic        [31:0] paddr, pwdata, prdata, rd;
  logic signed [15:0] drive_cmd;
  logic signed [7:0]  push_cnt;
  int                 fails, compares;

  servo_axis #(.TICK_CYCLES(20)) i_dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .drive_cmd(drive_cmd), .drive_en(drive_en),
    .irq(irq));
  drive_model i_drive (.mclk(mclk), .srst(srst), .drive_cmd(drive_cmd), .drive_en(drive_en),
    .push(push), .push_cnt(push_cnt), .enc_a(enc_a), .enc_b(enc_b));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {24'h0, a};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      end_sim();
    end
    rd = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_state(input logic [3:0] st);
    int n;
    n = 0;
    do begin
      apb(1'b0, servo_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rd[3:0] !== st && n < 3000);
    chk(rd[3:0], st);
    if (rd[3:0] !== st) end_sim();
  endtask

  task automatic nudge(input logic signed [7:0] c);
    @(posedge mclk);
    push     <= 1'b1;
    push_cnt <= c;
    @(posedge mclk);
    push <= 1'b0;
  endtask

  // drive must stay silent for n cycles
  task automatic quiet(input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      if (drive_en !== 1'b0 || drive_cmd !== 16'sh0) bad = 1'b1;
    end
    chk(bad, 1'b0);
  endtask

  // a positive displacement must be answered by a negative command
  task automatic react;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(drive_en === 1'b1 && drive_cmd < 0) && n < 400);
    chk(n < 400, 1'b1);
    if (!(drive_en === 1'b1 && drive_cmd < 0)) end_sim();
  endtask

  task automatic t_reset;
    apb(1'b0, servo_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, servo_pkg::OFS_GAIN, 32'h0);
    chk(rd, {24'h0, servo_pkg::RST_KP});
    apb(1'b0, 8'h34, 32'h0);
    chk(perr, 1'b1);
    chk(irq, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_fault;
    apb(1'b1, servo_pkg::OFS_IRQ_MASK, 32'h7);
    apb(1'b1, servo_pkg::OFS_CMD, 32'h2);
    apb(1'b0, servo_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    chk(irq, 1'b1);
    apb(1'b0, servo_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rd[servo_pkg::IRQ_FAULT], 1'b1);
    apb(1'b0, servo_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    $display("test fault done");
  endtask

  task automatic t_profile;
    apb(1'b1, servo_pkg::OFS_SPEED, 32'd1000);
    apb(1'b1, servo_pkg::OFS_ACCEL, 32'd50000);
    apb(1'b1, servo_pkg::OFS_GAIN, 32'h0);
    apb(1'b1, servo_pkg::OFS_CMD, 32'h1);
    apb(1'b0, servo_pkg::OFS_SPEED, 32'h0);
    chk(rd, 32'd1000);
    apb(1'b0, servo_pkg::OFS_GAIN, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, servo_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h11);
    apb(1'b1, servo_pkg::OFS_SPEED, 32'd2000);
    apb(1'b1, servo_pkg::OFS_GAIN, 32'h8);
    apb(1'b1, servo_pkg::OFS_CMD, 32'h1);
    apb(1'b0, servo_pkg::OFS_ACCEL, 32'h0);
    chk(rd, 32'd50000);
    apb(1'b0, servo_pkg::OFS_SPEED, 32'h0);
    chk(rd, 32'd2000);
    apb(1'b0, servo_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rd[servo_pkg::IRQ_APPLIED], 1'b1);
    $display("test profile done");
  endtask

  task automatic t_move;
    apb(1'b1, servo_pkg::OFS_TARGET, 32'd200);
    apb(1'b1, servo_pkg::OFS_CMD, 32'h2);
    wait_state(4'h2);
    apb(1'b1, servo_pkg::OFS_ACCEL, 32'd100000);
    apb(1'b1, servo_pkg::OFS_DECEL, 32'd100000);
    apb(1'b1, servo_pkg::OFS_CMD, 32'h1);
    apb(1'b0, servo_pkg::OFS_ACCEL, 32'h0);
    chk(rd, 32'd100000);
    apb(1'b0, servo_pkg::OFS_DECEL, 32'h0);
    chk(rd, 32'd100000);
    wait_state(4'h4);
    wait_state(4'h8);
    wait_state(4'h1);
    apb(1'b0, servo_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rd[servo_pkg::IRQ_DONE], 1'b1);
    $display("test move done");
  endtask

  task automatic t_hold;
    repeat (400) @(posedge mclk);
    nudge(8'sd6);
    react();
    apb(1'b1, servo_pkg::OFS_HOLD, {16'd10, 16'h1});
    apb(1'b1, servo_pkg::OFS_CMD, 32'h1);
    repeat (400) @(posedge mclk);
    nudge(8'sd4);
    quiet(300);
    nudge(8'sd12);
    react();
    apb(1'b1, servo_pkg::OFS_HOLD, 32'h2);
    apb(1'b1, servo_pkg::OFS_CMD, 32'h1);
    repeat (100) @(posedge mclk);
    nudge(8'sd20);
    quiet(400);
    apb(1'b0, servo_pkg::OFS_ERR, 32'h0);
    chk(rd, 32'h0);
    $display("test hold done");
  endtask

  initial begin
    fails = 0;
    compares = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    push = 1'b0;
    push_cnt = 8'sh0;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_fault();
    t_profile();
    t_move();
    t_hold();
    end_sim();
  end
endmodule // testbench

// ### hdl/servo_axis.sv
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module servo_axis #(
  parameter int unsigned TICK_CYCLES = servo_pkg::TICK_CYCLES
) (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic        [31:0] paddr,
  input  wire logic        [31:0] pwdata,
  output logic             [31:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               enc_a,
  input  wire logic               enc_b,
  output logic signed      [15:0] drive_cmd,
  output logic                    drive_en,
  output logic                    irq
);
  localparam int unsigned FB = servo_pkg::FRAC_BITS;

  typedef struct packed {
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic [31:0]           st_spd;
    logic [31:0]           st_acc;
    logic [31:0]           st_dec;
    logic [7:0]            st_kp;
    logic [7:0]            st_ki;
    logic [7:0]            st_kd;
    logic [1:0]            st_mode;
    logic [15:0]           st_band;
    logic [4:0]            st_spec;
    logic [31:0]           spd;
    logic [31:0]           acc;
    logic [31:0]           dec;
    logic [7:0]            kp;
    logic [7:0]            ki;
    logic [7:0]            kd;
    logic [1:0]            mode;
    logic [15:0]           band;
    logic [31:0]           target;
    logic                  profiled;
    servo_pkg::motion_t    motion;
    logic [42:0]           vel_fx;
    logic signed [42:0]    cmd_fx;
    logic                  a_s1;
    logic                  a_s2;
    logic                  a_s3;
    logic                  b_s1;
    logic                  b_s2;
    logic                  b_s3;
    logic signed [31:0]    enc_pos;
    logic [servo_pkg::IRQ_W-1:0] irq_stat;
    logic [servo_pkg::IRQ_W-1:0] irq_mask;
    logic                  irq;
  } axis_state_t;

  axis_state_t                 q;
  axis_state_t                 n;
  logic                        tick;
  logic                        mapped;
  logic                        wr_done;
  logic                        rd_done;
  logic                        apply_req;
  logic                        move_req;
  logic [servo_pkg::IRQ_W-1:0] ev;
  logic [31:0]                 dec_eff;
  logic signed [43:0]          diff_fx;
  logic [43:0]                 dist_fx;
  logic [65:0]                 v_sq;
  logic [65:0]                 brake_lim;
  logic [42:0]                 step_fx;
  logic [42:0]                 spd_fx;
  logic signed [31:0]          pos_err;
  logic [31:0]                 abs_err;
  logic                        at_rest;
  logic                        pid_en;
  logic                        pid_clr;
  logic signed [15:0]          pid_drv;
  logic                        pid_drv_en;

  servo_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .mclk (mclk),
    .srst (srst),
    .tick (tick)
  );

  // correction gating per holding mode
  always_comb begin
    pos_err = q.cmd_fx[42:11] - q.enc_pos;
    abs_err = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);
    at_rest = (q.motion == servo_pkg::MS_STOP);
    pid_clr = !q.profiled || (at_rest && q.mode == servo_pkg::HOLD_OFF);
    pid_en  = q.profiled && !pid_clr
              && !(at_rest && q.mode == servo_pkg::HOLD_BAND && abs_err <= {16'h0, q.band});
  end

  servo_pid u_pid (
    .mclk   (mclk),
    .srst   (srst),
    .tick   (tick),
    .en     (pid_en),
    .clr    (pid_clr),
    .err    (pos_err),
    .kp     (q.kp),
    .ki     (q.ki),
    .kd     (q.kd),
    .drv    (pid_drv),
    .drv_en (pid_drv_en)
  );

  always_comb begin
    n         = q;
    ev        = '0;
    apply_req = 1'b0;
    move_req  = 1'b0;
    mapped    = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'h0) && (paddr[7:0] <= servo_pkg::OFS_IRQ_MASK);
    wr_done   = psel && penable && q.pready && pwrite;
    rd_done   = psel && penable && q.pready && !pwrite;

    // one wait state: data and pready come out of flops together
    n.pready  = psel && penable && !q.pready;
    n.pslverr = n.pready && !mapped;
    n.prdata  = 32'h0;
    if (n.pready && !pwrite && mapped) begin
      unique case (paddr[7:0])
        servo_pkg::OFS_SPEED:    n.prdata = q.spd;
        servo_pkg::OFS_ACCEL:    n.prdata = q.acc;
        servo_pkg::OFS_DECEL:    n.prdata = q.dec;
        servo_pkg::OFS_GAIN:     n.prdata = {8'h0, q.kd, q.ki, q.kp};
        servo_pkg::OFS_HOLD:     n.prdata = {q.band, 14'h0, q.mode};
        servo_pkg::OFS_TARGET:   n.prdata = q.target;
        servo_pkg::OFS_STATUS:   n.prdata = {27'h0, q.profiled, q.motion};
        servo_pkg::OFS_POS:      n.prdata = q.enc_pos;
        servo_pkg::OFS_ERR:      n.prdata = pos_err;
        servo_pkg::OFS_DRIVE:    n.prdata = {{16{pid_drv[15]}}, pid_drv};
        servo_pkg::OFS_IRQ_STAT: n.prdata = {29'h0, q.irq_stat};
        servo_pkg::OFS_IRQ_MASK: n.prdata = {29'h0, q.irq_mask};
        default:                 n.prdata = 32'h0;
      endcase
    end

    if (wr_done && mapped) begin
      unique case (paddr[7:0])
        servo_pkg::OFS_SPEED: begin
          n.st_spd     = pwdata;
          n.st_spec[0] = 1'b1;
        end
        servo_pkg::OFS_ACCEL: begin
          n.st_acc     = pwdata;
          n.st_spec[1] = 1'b1;
        end
        servo_pkg::OFS_DECEL: begin
          n.st_dec     = pwdata;
          n.st_spec[2] = 1'b1;
        end
        servo_pkg::OFS_GAIN: begin
          n.st_kp      = pwdata[servo_pkg::GAIN_P_LSB +: 8];
          n.st_ki      = pwdata[servo_pkg::GAIN_I_LSB +: 8];
          n.st_kd      = pwdata[servo_pkg::GAIN_D_LSB +: 8];
          n.st_spec[3] = 1'b1;
        end
        servo_pkg::OFS_HOLD: begin
          n.st_mode    = pwdata[1:0];
          n.st_band    = pwdata[servo_pkg::HOLD_BAND_LSB +: 16];
          n.st_spec[4] = 1'b1;
        end
        servo_pkg::OFS_TARGET:   n.target   = pwdata;
        servo_pkg::OFS_CMD: begin
          apply_req = pwdata[servo_pkg::CMD_APPLY_BIT];
          move_req  = pwdata[servo_pkg::CMD_MOVE_BIT];
        end
        servo_pkg::OFS_IRQ_MASK: n.irq_mask = pwdata[servo_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end

    // profile load: only re-specified fields move, the rest stay
    if (apply_req) begin
      if (n.st_spec[0]) n.spd = n.st_spd;
      if (n.st_spec[1]) n.acc = n.st_acc;
      if (n.st_spec[2]) n.dec = n.st_dec;
      if (n.st_spec[3]) begin
        n.kp = (n.st_kp == 8'h00) ? servo_pkg::RST_KP : n.st_kp;
        n.ki = n.st_ki;
        n.kd = n.st_kd;
      end
      if (n.st_spec[4]) begin
        n.mode = n.st_mode;
        n.band = n.st_band;
      end
      n.st_spec  = '0;
      n.profiled = 1'b1;
      ev[servo_pkg::IRQ_APPLIED] = 1'b1;
    end

    if (move_req) begin
      if (!n.profiled) begin
        ev[servo_pkg::IRQ_FAULT] = 1'b1;
      end else if (q.motion == servo_pkg::MS_STOP) begin
        n.motion = servo_pkg::MS_ACCEL;
      end
    end

    // trajectory, one step per servo tick
    dec_eff   = (q.dec == 32'h0) ? q.acc : q.dec;
    diff_fx   = 44'($signed({n.target, 11'h0})) - 44'(q.cmd_fx);
    dist_fx   = diff_fx[43] ? 44'(-diff_fx) : 44'(diff_fx);
    v_sq      = 66'(q.vel_fx[42:11]) * 66'(q.vel_fx[42:11]);
    brake_lim = 66'({dist_fx[43:11], 1'b0}) * 66'(dec_eff);
    spd_fx    = {q.spd, 11'h0};
    step_fx   = q.vel_fx;
    if (tick) begin
      if (q.motion == servo_pkg::MS_STOP) begin
        n.vel_fx = 43'h0;
        // let the axis drift freely and re-anchor to it
        if (q.mode == servo_pkg::HOLD_OFF) n.cmd_fx = {q.enc_pos[31], q.enc_pos, 10'h0} <<< 1;
      end else if (n.motion != servo_pkg::MS_STOP) begin
        if (v_sq >= brake_lim && q.vel_fx != 43'h0) begin
          n.motion = servo_pkg::MS_DECEL;
          n.vel_fx = (q.vel_fx > 43'(dec_eff) + 43'h800) ? q.vel_fx - 43'(dec_eff) : 43'h800;
        end else if (q.vel_fx >= spd_fx) begin
          n.motion = servo_pkg::MS_SLEW;
          n.vel_fx = spd_fx;
        end else begin
          n.motion = servo_pkg::MS_ACCEL;
          n.vel_fx = (q.vel_fx + 43'(q.acc) > spd_fx) ? spd_fx : q.vel_fx + 43'(q.acc);
        end
        step_fx = {11'h0, n.vel_fx[42:11]};
        if (dist_fx <= 44'(step_fx)) begin
          n.cmd_fx = $signed({n.target, 11'h0});
          n.vel_fx = 43'h0;
          n.motion = servo_pkg::MS_STOP;
          ev[servo_pkg::IRQ_DONE] = 1'b1;
        end else begin
          n.cmd_fx = diff_fx[43] ? q.cmd_fx - $signed(step_fx) : q.cmd_fx + $signed(step_fx);
        end
      end
    end

    // encoder: synchronise, then x4 decode
    n.a_s1 = enc_a;
    n.a_s2 = q.a_s1;
    n.a_s3 = q.a_s2;
    n.b_s1 = enc_b;
    n.b_s2 = q.b_s1;
    n.b_s3 = q.b_s2;
    if ((q.a_s2 ^ q.a_s3) || (q.b_s2 ^ q.b_s3)) begin
      n.enc_pos = (q.a_s3 ^ q.b_s2) ? q.enc_pos + 32'sh1 : q.enc_pos - 32'sh1;
    end

    // a new event in the clearing read survives it
    n.irq_stat = ((rd_done && paddr == 32'(servo_pkg::OFS_IRQ_STAT)) ? '0 : q.irq_stat) | ev;
    n.irq      = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q        <= '0;
      q.kp     <= servo_pkg::RST_KP;
      q.motion <= servo_pkg::MS_STOP;
    end else begin
      q <= n;
    end
  end

  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign irq       = q.irq;
  assign drive_cmd = pid_drv;
  assign drive_en  = pid_drv_en;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_apb_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after exactly one wait state");
  a_move_fault: assert property (move_req && !n.profiled |=> q.irq_stat[servo_pkg::IRQ_FAULT])
    else $error("move without profile raised no fault");
  a_move_blocked: assert property (!q.profiled && !apply_req |=> $past(q.motion) == q.motion)
    else $error("axis moved without a profile");
  // the staged flags are cleared in the loading cycle, so look at them before the edge
  a_keep_unspec: assert property (apply_req && !q.st_spec[0] |=> q.spd == $past(q.spd))
    else $error("unspecified speed changed on profile load");
  a_ramp_now: assert property (apply_req && q.st_spec[1] |=> q.acc == $past(q.st_acc))
    else $error("new acceleration not applied at once");
  a_kp_range: assert property (q.kp != 8'h00)
    else $error("proportional gain left its range");
  a_slew_speed: assert property (tick && q.motion != servo_pkg::MS_STOP
                                 ##1 q.motion == servo_pkg::MS_SLEW |-> q.vel_fx == {q.spd, 11'h0})
    else $error("slewing velocity differs from maximum speed");
  a_stop_still: assert property (q.motion == servo_pkg::MS_STOP |-> q.vel_fx == 43'h0)
    else $error("stopped axis still has velocity");
  a_state_on_tick: assert property (!tick && !move_req |=> $stable(q.motion))
    else $error("motion state changed outside a servo tick");
  a_band_quiet: assert property (tick && q.mode == servo_pkg::HOLD_BAND && at_rest && q.profiled
                                 && abs_err <= {16'h0, q.band} |=> !drive_en && drive_cmd == 16'sh0)
    else $error("correction inside the deadband");
  a_seek_hold: assert property (tick && q.mode == servo_pkg::HOLD_SEEK && q.profiled |=> drive_en)
    else $error("seek mode not correcting");
  a_irq_level: assert property (irq == |(q.irq_stat & q.irq_mask))
    else $error("interrupt does not follow masked status");

  c_move_done: cover property (q.motion == servo_pkg::MS_DECEL ##[1:1000] q.motion == servo_pkg::MS_STOP);
  c_slew: cover property (q.motion == servo_pkg::MS_SLEW);
  c_fault: cover property (ev[servo_pkg::IRQ_FAULT]);
  c_band_quiet: cover property (q.mode == servo_pkg::HOLD_BAND && at_rest && q.profiled && !pid_en);
endmodule // servo_axis

// ### hdl/servo_pid.sv
`timescale 1ns/100ps
module servo_pid (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               tick,
  input  wire logic               en,
  input  wire logic               clr,
  input  wire logic signed [31:0] err,
  input  wire logic        [7:0]  kp,
  input  wire logic        [7:0]  ki,
  input  wire logic        [7:0]  kd,
  output logic signed      [15:0] drv,
  output logic                    drv_en
);
  localparam logic signed [31:0] CUM_LIM = 32'sh3FFFFFFF;
  localparam logic signed [43:0] OUT_MAX = 44'sh00000007FFF;
  localparam logic signed [43:0] OUT_MIN = -44'sh00000008000;

  typedef struct packed {
    logic signed [15:0] drv;
    logic               drv_en;
    logic signed [31:0] cum;
    logic signed [31:0] last;
  } pid_state_t;

  pid_state_t         q;
  pid_state_t         n;
  logic signed [43:0] p_term;
  logic signed [43:0] d_term;
  logic signed [43:0] i_term;
  logic signed [43:0] sum;
  logic signed [32:0] cum_nx;

  always_comb begin
    n      = q;
    p_term = 44'(err) * 44'($signed({1'b0, kp}));
    d_term = (44'(err) - 44'(q.last)) * 44'($signed({1'b0, kd}));
    i_term = 44'(q.cum) * 44'($signed({1'b0, ki}));
    sum    = p_term + d_term + i_term;
    cum_nx = 33'(err) + 33'(q.cum);
    if (clr) begin
      n = '0;
    end else if (tick) begin
      if (en) begin
        // clamp instead of wrap so a long stall cannot flip the sign
        if (sum > OUT_MAX) n.drv = OUT_MAX[15:0];
        else if (sum < OUT_MIN) n.drv = OUT_MIN[15:0];
        else n.drv = sum[15:0];
        if (cum_nx > 33'(CUM_LIM)) n.cum = CUM_LIM;
        else if (cum_nx < -33'(CUM_LIM)) n.cum = -CUM_LIM;
        else n.cum = cum_nx[31:0];
        n.last   = err;
        n.drv_en = 1'b1;
      end else begin
        n.drv    = 16'sh0000;
        n.drv_en = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign drv    = q.drv;
  assign drv_en = q.drv_en;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_quiet_when_off: assert property (tick && !en |=> drv == 16'sh0000 && !drv_en)
    else $error("drive not quiet while correction is off");
  a_last_err_kept: assert property (tick && en && !clr |=> q.last == $past(err))
    else $error("previous error not recorded on a servo tick");
  a_cum_grows: assert property (tick && en && !clr && q.cum == 32'sh0 |=> q.cum == $past(err))
    else $error("cumulative error not summed");
  c_drive_active: cover property (tick && en ##1 drv != 16'sh0000);
endmodule // servo_pid

// ### hdl/servo_pkg.sv
package servo_pkg;
  // servo calculation rate
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned SERVO_HZ    = 2048;
  localparam int unsigned TICK_CYCLES = CLK_HZ / SERVO_HZ;
  localparam int unsigned FRAC_BITS   = 11;

  // register byte offsets
  localparam logic [7:0] OFS_SPEED    = 8'h00;
  localparam logic [7:0] OFS_ACCEL    = 8'h04;
  localparam logic [7:0] OFS_DECEL    = 8'h08;
  localparam logic [7:0] OFS_GAIN     = 8'h0C;
  localparam logic [7:0] OFS_HOLD     = 8'h10;
  localparam logic [7:0] OFS_TARGET   = 8'h14;
  localparam logic [7:0] OFS_CMD      = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1C;
  localparam logic [7:0] OFS_POS      = 8'h20;
  localparam logic [7:0] OFS_ERR      = 8'h24;
  localparam logic [7:0] OFS_DRIVE    = 8'h28;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

  // field positions
  localparam int unsigned GAIN_P_LSB    = 0;
  localparam int unsigned GAIN_I_LSB    = 8;
  localparam int unsigned GAIN_D_LSB    = 16;
  localparam int unsigned HOLD_BAND_LSB = 16;
  localparam int unsigned CMD_APPLY_BIT = 0;
  localparam int unsigned CMD_MOVE_BIT  = 1;
  localparam int unsigned STAT_PROF_BIT = 4;
  localparam int unsigned IRQ_DONE      = 0;
  localparam int unsigned IRQ_FAULT     = 1;
  localparam int unsigned IRQ_APPLIED   = 2;
  localparam int unsigned IRQ_W         = 3;

  // holding modes
  localparam logic [1:0] HOLD_SEEK = 2'h0;
  localparam logic [1:0] HOLD_BAND = 2'h1;
  localparam logic [1:0] HOLD_OFF  = 2'h2;

  // reset values
  localparam logic [7:0] RST_KP = 8'h01;

  typedef enum logic [3:0] {
    MS_STOP  = 4'h1,
    MS_ACCEL = 4'h2,
    MS_SLEW  = 4'h4,
    MS_DECEL = 4'h8
  } motion_t;
endpackage

// ### hdl/servo_tick.sv
`timescale 1ns/100ps
module servo_tick #(
  parameter int unsigned TICK_CYCLES = servo_pkg::TICK_CYCLES
) (
  input  wire logic mclk,
  input  wire logic srst,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tick_state_t;

  tick_state_t q;
  tick_state_t n;

  always_comb begin
    n = q;
    n.tick = 1'b0;
    if (q.cnt == 32'(TICK_CYCLES - 1)) begin
      n.cnt  = 32'h0;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = q.tick;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_tick_spacing: assert property (tick |=> !tick [*8])
    else $error("servo ticks closer than expected");
endmodule // servo_tick
